//--- core/usp_pkg.sv
// constants, register map and decode for the serial data port block
package usp_pkg;
  // register indices; byte address is four times the sum of base and index
  localparam logic [9:0]  BLOCK_BASE    = 10'h200;
  localparam logic [9:0]  NONBLOCK_BASE = 10'h300;
  localparam logic [9:0]  CTRL_IDX      = 10'h046;
  localparam logic [9:0]  DATA_IDX      = 10'h047;
  localparam logic [9:0]  STAT_IDX      = 10'h048;
  localparam logic [9:0]  MASK_IDX      = 10'h049;
  localparam logic [9:0]  CFG_IDX       = 10'h04A;
  localparam logic [9:0]  BAUD_IDX      = 10'h04B;
  // serial_error_irq_control fields
  localparam int          CTRL_R8       = 7;
  localparam int          CTRL_T8       = 6;
  localparam int          CTRL_TX_POLARITY_INVERT    = 4;
  // status and mask layout; bits 3..0 share positions with the enables
  localparam int          ST_RXFULL     = 5;
  localparam int          ST_TXEMPTY    = 4;
  localparam int          ST_OVERRUN    = 3;
  localparam int          ST_NOISE      = 2;
  localparam int          ST_FRAMING    = 1;
  localparam int          ST_PARITY     = 0;
  // configuration fields
  localparam int          CFG_TXEN      = 0;
  localparam int          CFG_RXEN      = 1;
  localparam int          CFG_NINE      = 2;
  localparam int          CFG_PAREN     = 3;
  localparam int          CFG_PARODD    = 4;
  // values after reset
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [7:0]  DATA_RESET    = 8'h00;
  localparam logic [8:0]  TXBUF_RESET   = 9'h000;
  localparam logic [5:0]  MASK_RESET    = 6'h00;
  localparam logic [4:0]  CFG_RESET     = 5'h03;
  localparam logic [12:0] BAUD_RESET    = 13'h0036;
  // oversampling phases within one bit time
  localparam logic [3:0]  PH_SAMPLE_A   = 4'h7;
  localparam logic [3:0]  PH_SAMPLE_B   = 4'h8;
  localparam logic [3:0]  PH_DECIDE     = 4'h9;
  localparam logic [3:0]  PH_LAST       = 4'hF;

  typedef enum logic [2:0] {
    REG_NONE, REG_CTRL, REG_DATA, REG_STAT, REG_MASK, REG_CFG, REG_BAUD
  } usp_reg_t;

  // map a byte address onto a register, either base window
  function automatic usp_reg_t usp_decode(input logic [11:0] adr);
    logic [9:0] idx;
    usp_reg_t   r;
    idx = adr[11:2];
    r   = REG_NONE;
    if (idx >= BLOCK_BASE && idx < NONBLOCK_BASE) begin
      idx = idx - BLOCK_BASE;
    end else if (idx >= NONBLOCK_BASE) begin
      idx = idx - NONBLOCK_BASE;
    end else begin
      idx = 10'h3FF;
    end
    if (adr[1:0] == 2'h0) begin
      case (idx)
        CTRL_IDX: r = REG_CTRL;
        DATA_IDX: r = REG_DATA;
        STAT_IDX: r = REG_STAT;
        MASK_IDX: r = REG_MASK;
        CFG_IDX:  r = REG_CFG;
        BAUD_IDX: r = REG_BAUD;
        default:  r = REG_NONE;
      endcase
    end
    return r;
  endfunction
endpackage

//--- core/usp_link_if.sv
// signals between the register core and the serial shifters
`timescale 1ns/1ns
interface usp_link_if;
  logic       tick;
  logic       nine_bit;
  logic       par_en;
  logic       par_odd;
  logic       tx_start;
  logic [8:0] tx_data;
  logic       tx_ready;
  logic       tx_line;
  logic       rx_en;
  logic       rx_line;
  logic       rx_done;
  logic [8:0] rx_data;
  logic       rx_noise;
  logic       rx_framing;
  logic       rx_parity;

  modport core (output tick, nine_bit, par_en, par_odd, tx_start, tx_data, rx_en,
                rx_line, input tx_ready, tx_line, rx_done, rx_data, rx_noise,
                rx_framing, rx_parity);
  modport tx_side (input tick, nine_bit, par_en, par_odd, tx_start, tx_data,
                   output tx_ready, tx_line);
  modport rx_side (input tick, nine_bit, par_en, par_odd, rx_en, rx_line,
                   output rx_done, rx_data, rx_noise, rx_framing, rx_parity);
endinterface

//--- core/usp_tx.sv
// transmit shifter: start, 8 or 9 data bits lsb first, stop
`timescale 1ns/1ns
module usp_tx (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // link to the core
  usp_link_if.tx_side link
);
  typedef enum logic {TX_IDLE, TX_SHIFT} usp_tx_state_t;
  usp_tx_state_t state, next_state;
  logic [10:0]   shreg, next_shreg;
  logic [3:0]    bitcnt, next_bitcnt;
  logic [3:0]    phase, next_phase;
  logic          line, next_line;
  logic [8:0]    word;

  assign link.tx_ready = (state == TX_IDLE);
  assign link.tx_line  = line;

  // frame build, parity replaces the top data bit when enabled
  always_comb begin
    word = link.nine_bit ? link.tx_data : {1'b1, link.tx_data[7:0]};
    if (link.par_en && link.nine_bit) begin
      word[8] = ^link.tx_data[7:0] ^ link.par_odd;
    end else if (link.par_en) begin
      word[7] = ^link.tx_data[6:0] ^ link.par_odd;
    end
    next_state  = state;
    next_shreg  = shreg;
    next_bitcnt = bitcnt;
    next_phase  = phase;
    unique case (state)
      TX_IDLE: begin
        if (link.tx_start) begin
          next_shreg  = {1'b1, word, 1'b0}; // low start, high stop
          next_bitcnt = 4'h0;
          next_phase  = 4'h0;
          next_state  = TX_SHIFT;
        end
      end
      TX_SHIFT: begin
        if (link.tick) begin // paced by the shared baud tick
          next_phase = phase + 4'h1;
          if (phase == usp_pkg::PH_LAST) begin
            next_shreg  = {1'b1, shreg[10:1]};
            next_bitcnt = bitcnt + 4'h1;
            if (bitcnt == (link.nine_bit ? 4'hA : 4'h9)) begin
              next_state = TX_IDLE;
            end
          end
        end
      end
    endcase
    next_line = (next_state == TX_SHIFT) ? next_shreg[0] : 1'b1;
  end

  // registered shifter state
  always_ff @(posedge clk) begin
    if (reset) begin
      state  <= TX_IDLE;
      shreg  <= 11'h7FF;
      bitcnt <= 4'h0;
      phase  <= 4'h0;
      line   <= 1'b1;
    end else begin
      state  <= next_state;
      shreg  <= next_shreg;
      bitcnt <= next_bitcnt;
      phase  <= next_phase;
      line   <= next_line;
    end
  end
endmodule

//--- core/usp_rx.sv
// receive shifter: 16x oversampling, vote of three samples mid bit
`timescale 1ns/1ns
module usp_rx (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // link to the core
  usp_link_if.rx_side link
);
  typedef enum logic {RX_IDLE, RX_BITS} usp_rx_state_t;
  usp_rx_state_t state, next_state;
  logic [8:0]    shreg, next_shreg;
  logic [3:0]    bitcnt, next_bitcnt;
  logic [3:0]    phase, next_phase;
  logic          s_a, next_s_a, s_b, next_s_b;
  logic          noise, next_noise;
  logic          done, next_done;
  logic          ferr, next_ferr;
  logic          vote;
  logic [8:0]    word;

  assign word             = link.nine_bit ? shreg : {1'b0, shreg[8:1]};
  assign link.rx_done     = done;
  assign link.rx_data     = word;
  assign link.rx_noise    = noise;
  assign link.rx_framing  = ferr;
  assign link.rx_parity   = link.par_en && ((^word) != link.par_odd);

  // runs on its own, never looks at the transmit side
  always_comb begin
    vote        = (s_a & s_b) | (s_a & link.rx_line) | (s_b & link.rx_line);
    next_state  = state;
    next_shreg  = shreg;
    next_bitcnt = bitcnt;
    next_phase  = phase;
    next_s_a    = s_a;
    next_s_b    = s_b;
    next_noise  = noise;
    next_ferr   = ferr;
    next_done   = 1'b0;
    unique case (state)
      RX_IDLE: begin
        if (link.rx_en && link.tick && !link.rx_line) begin
          next_state  = RX_BITS;
          next_phase  = 4'h1;
          next_bitcnt = 4'h0;
          next_noise  = 1'b0;
        end
      end
      RX_BITS: begin
        if (link.tick) begin
          next_phase = phase + 4'h1;
          if (phase == usp_pkg::PH_SAMPLE_A) next_s_a = link.rx_line;
          if (phase == usp_pkg::PH_SAMPLE_B) next_s_b = link.rx_line;
          if (phase == usp_pkg::PH_DECIDE) begin
            next_bitcnt = bitcnt + 4'h1;
            next_noise  = noise | (s_a != s_b) | (s_b != link.rx_line);
            if (bitcnt == 4'h0 && vote) begin
              next_state = RX_IDLE; // start bit did not hold low
            end else if (bitcnt == (link.nine_bit ? 4'hA : 4'h9)) begin
              next_ferr  = !vote; // stop must be high
              next_done  = 1'b1;
              next_state = RX_IDLE;
            end else if (bitcnt != 4'h0) begin
              next_shreg = {vote, shreg[8:1]}; // lsb arrives first
            end
          end
        end
      end
    endcase
  end

  // registered receiver state
  always_ff @(posedge clk) begin
    if (reset) begin
      state  <= RX_IDLE;
      shreg  <= 9'h000;
      bitcnt <= 4'h0;
      phase  <= 4'h0;
      s_a    <= 1'b1;
      s_b    <= 1'b1;
      noise  <= 1'b0;
      ferr   <= 1'b0;
      done   <= 1'b0;
    end else begin
      state  <= next_state;
      shreg  <= next_shreg;
      bitcnt <= next_bitcnt;
      phase  <= next_phase;
      s_a    <= next_s_a;
      s_b    <= next_s_b;
      noise  <= next_noise;
      ferr   <= next_ferr;
      done   <= next_done;
    end
  end
endmodule

//--- core/usp_data_port.sv
// serial unit top: wishbone registers, data port, error interrupts
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ns
module usp_data_port (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // interrupt
  output logic             irq,
  // serial line
  input  wire logic        serial_rx_in,
  output logic             serial_tx_out
);
  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0]  ctrl, next_ctrl;
  logic [7:0]  rx_buf, next_rx_buf;
  logic [8:0]  tx_buf, next_tx_buf;
  logic        tx_full, next_tx_full;
  logic [3:0]  err, next_err;
  logic        rx_full, next_rx_full;
  logic        armed, next_armed;
  logic [5:0]  mask, next_mask;
  logic [4:0]  cfg, next_cfg;
  logic [12:0] baud, next_baud;
  logic [12:0] baud_cnt, next_baud_cnt;
  logic        tick, next_tick;
  logic        next_ack;
  logic [31:0] next_dat;
  logic        next_irq;
  logic        next_tx_out;
  logic        rx_s1, rx_s2, rx_s3;
  logic        rx_level, next_rx_level;
  // bus decode
  logic              req, wr, rd;
  usp_pkg::usp_reg_t sel;
  logic [5:0]        status;

  usp_link_if link ();

  ////////////////////////////////////////////////////////////////////////////
  // shifters
  usp_tx u_tx (
    .clk   (clk),
    .reset (reset),
    .link  (link.tx_side)
  );

  usp_rx u_rx (
    .clk   (clk),
    .reset (reset),
    .link  (link.rx_side)
  );

  // core side of the link
  assign link.tick     = tick;
  assign link.nine_bit = cfg[usp_pkg::CFG_NINE];
  assign link.par_en   = cfg[usp_pkg::CFG_PAREN];
  assign link.par_odd  = cfg[usp_pkg::CFG_PARODD];
  assign link.rx_en    = cfg[usp_pkg::CFG_RXEN];
  assign link.rx_line  = rx_level;
  assign link.tx_data  = tx_buf;
  // buffer moves into the shifter as soon as the shifter is free and transmit is enabled
  assign link.tx_start = tx_full && link.tx_ready && cfg[usp_pkg::CFG_TXEN];

  ////////////////////////////////////////////////////////////////////////////
  // bus request decode
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr  = req && wb_we_i;
  assign rd  = req && !wb_we_i;
  assign sel = usp_pkg::usp_decode(wb_adr_i); // both base windows

  // live status word seen by software
  always_comb begin
    status                        = 6'h00;
    status[usp_pkg::ST_RXFULL]    = rx_full;
    status[usp_pkg::ST_TXEMPTY]   = !tx_full;
    status[3:0]                   = err;
  end

  ////////////////////////////////////////////////////////////////////////////
  // baud generator: one 16x tick feeds both shifters
  always_comb begin
    next_baud_cnt = baud_cnt + 13'h0001;
    next_tick     = 1'b0;
    if (baud == 13'h0000) begin
      next_baud_cnt = 13'h0000; // zero divisor parks the generator
    end else if (baud_cnt >= baud - 13'h0001) begin
      next_baud_cnt = 13'h0000;
      next_tick     = 1'b1; // single source for tx and rx
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive pin: three flops, change accepted when the last two agree
  always_comb begin
    next_rx_level = rx_level;
    if (rx_s2 == rx_s3) begin
      next_rx_level = rx_s3; // no shared clock, line sampled
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file, receive capture and flag sequences
  always_comb begin
    next_ctrl    = ctrl;
    next_rx_buf  = rx_buf;
    next_tx_buf  = tx_buf;
    next_tx_full = tx_full;
    next_err     = err;
    next_rx_full = rx_full;
    next_armed   = armed;
    next_mask    = mask;
    next_cfg     = cfg;
    next_baud    = baud;

    // clears first, so a same-cycle hardware set below wins
    if (link.tx_start) begin
      next_tx_full = 1'b0;
    end
    if (rd && sel == usp_pkg::REG_STAT && (rx_full || err != 4'h0)) begin
      next_armed = 1'b1; // first step of the clearing sequence
    end
    if (rd && sel == usp_pkg::REG_DATA && armed) begin
      next_rx_full = 1'b0; // second step completes it
      next_err     = 4'h0;
      next_armed   = 1'b0;
    end

    // software writes, lane 0 carries bits 7..0, lane 1 bits 15..8
    if (wr && wb_sel_i[0]) begin
      unique case (sel)
        usp_pkg::REG_CTRL: begin
          next_ctrl[6:0] = wb_dat_i[6:0]; // r8 is receive side only
        end
        usp_pkg::REG_DATA: begin
          // write lands in the transmit buffer only
          next_tx_buf  = {ctrl[usp_pkg::CTRL_T8], wb_dat_i[7:0]};
          next_tx_full = 1'b1; // empty flag drops with the write
        end
        usp_pkg::REG_STAT: begin
          next_err = next_err & ~wb_dat_i[3:0];
          if (wb_dat_i[usp_pkg::ST_RXFULL]) next_rx_full = 1'b0;
        end
        usp_pkg::REG_MASK: begin
          next_mask[5:4] = wb_dat_i[5:4];
        end
        usp_pkg::REG_CFG: begin
          next_cfg = wb_dat_i[4:0];
        end
        usp_pkg::REG_BAUD: begin
          next_baud[7:0] = wb_dat_i[7:0];
        end
        usp_pkg::REG_NONE: begin
        end
      endcase
    end
    if (wr && wb_sel_i[1] && sel == usp_pkg::REG_BAUD) begin
      next_baud[12:8] = wb_dat_i[12:8];
    end

    // a finished character, applied last so its sets win
    if (link.rx_done) begin
      if (rx_full) begin
        next_err[usp_pkg::ST_OVERRUN] = 1'b1; // new char dropped
      end else begin
        next_rx_buf                 = link.rx_data[7:0];
        next_ctrl[usp_pkg::CTRL_R8] = link.rx_data[8];
        next_rx_full                = 1'b1;
        next_armed                  = 1'b0;
        if (link.rx_noise) next_err[usp_pkg::ST_NOISE] = 1'b1;
        if (link.rx_framing) next_err[usp_pkg::ST_FRAMING] = 1'b1;
        if (link.rx_parity) next_err[usp_pkg::ST_PARITY] = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus answer: ack one cycle after the request, unmapped reads return zero
  always_comb begin
    next_ack = req;
    next_dat = 32'h0000_0000;
    if (rd) begin
      unique case (sel)
        usp_pkg::REG_CTRL: next_dat[7:0] = ctrl;
        usp_pkg::REG_DATA: next_dat[7:0] = rx_buf; // receive side
        usp_pkg::REG_STAT: next_dat[5:0] = status;
        usp_pkg::REG_MASK: next_dat[5:0] = {mask[5:4], ctrl[3:0]};
        usp_pkg::REG_CFG:  next_dat[4:0] = cfg;
        usp_pkg::REG_BAUD: next_dat[12:0] = baud;
        usp_pkg::REG_NONE: next_dat = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt and line output
  always_comb begin
    // per-flag enables of the error bits
    // one level request from all enabled sources
    next_irq = |(err & ctrl[3:0]) |
               |({rx_full, !tx_full} & mask[5:4]);
    // inverts data, start, stop and idle alike
    next_tx_out = link.tx_line ^ ctrl[usp_pkg::CTRL_TX_POLARITY_INVERT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl          <= usp_pkg::CTRL_RESET; // enables off
      rx_buf        <= usp_pkg::DATA_RESET;
      tx_buf        <= usp_pkg::TXBUF_RESET;
      tx_full       <= 1'b0;
      err           <= 4'h0;
      rx_full       <= 1'b0;
      armed         <= 1'b0;
      mask          <= usp_pkg::MASK_RESET;
      cfg           <= usp_pkg::CFG_RESET;
      baud          <= usp_pkg::BAUD_RESET;
      baud_cnt      <= 13'h0000;
      tick          <= 1'b0;
      wb_ack_o      <= 1'b0;
      wb_dat_o      <= 32'h0000_0000;
      irq           <= 1'b0;
      serial_tx_out <= 1'b1; // idle high, no inversion
      rx_s1         <= 1'b1;
      rx_s2         <= 1'b1;
      rx_s3         <= 1'b1;
      rx_level      <= 1'b1;
    end else begin
      ctrl          <= next_ctrl;
      rx_buf        <= next_rx_buf;
      tx_buf        <= next_tx_buf;
      tx_full       <= next_tx_full;
      err           <= next_err;
      rx_full       <= next_rx_full;
      armed         <= next_armed;
      mask          <= next_mask;
      cfg           <= next_cfg;
      baud          <= next_baud;
      baud_cnt      <= next_baud_cnt;
      tick          <= next_tick;
      wb_ack_o      <= next_ack;
      wb_dat_o      <= next_dat;
      irq           <= next_irq;
      serial_tx_out <= next_tx_out;
      rx_s1         <= serial_rx_in;
      rx_s2         <= rx_s1;
      rx_s3         <= rx_s2;
      rx_level      <= next_rx_level;
    end
  end
endmodule

//--- verif/usp_data_port_assertions.sv
// assertion checker for the serial data port top
`timescale 1ns/1ns
module usp_data_port_assertions (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // wishbone
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // interrupt and line
  input wire logic        irq,
  input wire logic        serial_rx_in,
  input wire logic        serial_tx_out
);
  logic [9:0] quiet, next_quiet;
  logic       inv, next_inv, hit;
  ////////////////////////////////////////////////////////////////
  // quiet time since a data or control write; frames end well inside 400
  always_comb begin
    hit = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i[9:3] == 7'h23 && wb_adr_i[1:0] == 2'h0;
    next_quiet = hit ? 10'h000 : quiet + {9'h000, quiet != 10'h3FF};
    next_inv = (hit && !wb_adr_i[2]) ? wb_dat_i[4] : inv;
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      quiet <= 10'h000;
      inv <= 1'b0;
    end else begin
      quiet <= next_quiet;
      inv <= next_inv;
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_odd_read;
    s_req ##0 (!wb_we_i && wb_adr_i[1:0] != 2'h0);
  endsequence
  AST_ACK_NEXT: assert property (s_req |=> wb_ack_o)
    else $error("request not acked after one cycle");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_DAT_QUIET: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  AST_ODD_ZERO: assert property (s_odd_read |=> wb_dat_o == 32'h0)
    else $error("misaligned read not zero");
  AST_RST_IRQ: assert property ($fell(reset) |-> !irq [*3])
    else $error("request after reset");
  AST_RST_IDLE: assert property ($fell(reset) |-> serial_tx_out [*3])
    else $error("line not idle high after reset");
  AST_IDLE_POL: assert property (quiet >= 10'd400 |-> serial_tx_out == !inv)
    else $error("idle level ignores polarity");
  AST_IRQ_FALL: assert property ($fell(irq) |-> $past(wb_ack_o) || $past(wb_ack_o, 2))
    else $error("request dropped with no access");
endmodule
bind usp_data_port usp_data_port_assertions chk (
  .clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_dat_o, .wb_ack_o, .irq, .serial_rx_in, .serial_tx_out
);

//--- verif/usp_remote_node.sv
// remote serial node on the far end of the line
`timescale 1ns/1ns
module usp_remote_node #(
  parameter int BIT_CLKS = 16
) (
  // clock
  input wire logic       clk,
  // line
  input wire logic       line_in,
  input wire logic       invert,
  output logic           line_out,
  // bench control
  input wire logic       send,
  input wire logic [7:0] send_byte,
  input wire logic       bad_stop,
  input wire logic       noisy,
  output logic           busy,
  output logic           got,
  output logic [7:0]     got_byte
);
  logic [7:0] sb;
  // sender: idles high between frames
  initial begin
    line_out = 1'b1;
    busy = 1'b0;
    forever begin
      @(posedge clk);
      if (send) begin
        sb = send_byte;
        busy <= 1'b1;
        line_out <= 1'b0;
        repeat (BIT_CLKS) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
          line_out <= sb[i];
          // two-clock spike in bit 0 survives the pin filter, splits the vote
          if (noisy && i == 0) begin
            repeat (6) @(posedge clk);
            line_out <= !sb[i];
            repeat (2) @(posedge clk);
            line_out <= sb[i];
            repeat (BIT_CLKS - 8) @(posedge clk);
          end else begin
            repeat (BIT_CLKS) @(posedge clk);
          end
        end
        line_out <= !bad_stop; // stop low only when a fault is wanted
        repeat (BIT_CLKS) @(posedge clk);
        line_out <= 1'b1;
        busy <= 1'b0;
      end
    end
  end
  // receiver: recheck at mid start so polarity switches do not frame
  initial begin
    got = 1'b0;
    got_byte = 8'h00;
    forever begin
      @(posedge clk);
      got <= 1'b0;
      if ((line_in ^ invert) == 1'b0) begin
        repeat (BIT_CLKS / 2) @(posedge clk);
        if ((line_in ^ invert) == 1'b0) begin
          for (int j = 0; j < 8; j++) begin
            repeat (BIT_CLKS) @(posedge clk);
            got_byte[j] <= line_in ^ invert;
          end
          repeat (BIT_CLKS) @(posedge clk);
          got <= line_in ^ invert;
        end
      end
    end
  end
endmodule

//--- verif/usp_data_port_tb.sv
// self-checking bench for the serial data port
`timescale 1ns/1ns
module usp_data_port_tb;
  logic        clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
  logic [11:0] wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, seed;
  logic        rx_line, tx_line, send, bad_stop, noisy, inv, busy, got;
  logic [7:0]  send_byte, got_byte, tx_b, rx_b;
  logic [7:0]  rd_v[$], rd_m[$], tx_q[$];
  int          err_total, n_tests;
  // error cases: parity, framing, overrun, noise
  logic [7:0]  cfg_t[4] = '{8'h0B, 8'h03, 8'h03, 8'h03};
  logic [7:0]  byt_t[4] = '{8'h01, 8'h55, 8'h3C, 8'h5A};
  logic        bad_t[4] = '{1'b0, 1'b1, 1'b0, 1'b0};
  int          bit_t[4] = '{0, 1, 3, 2};
  usp_data_port dut (.clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq, .serial_rx_in(rx_line), .serial_tx_out(tx_line));
  usp_remote_node node (.clk, .line_in(tx_line), .invert(inv), .line_out(rx_line), .send,
    .send_byte, .bad_stop, .noisy, .busy, .got, .got_byte);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic fail(input string s);
    err_total++;
    $display("CHECK FAILED at %0t: %s", $time, s);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic timeout(input string s);
    fail(s);
    report_and_stop();
  endtask
  task automatic chk(input logic g, input logic e, input string s);
    n_tests++;
    if (g !== e) fail(s);
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // one classic cycle; reads leave their expectation for the monitor
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [7:0] ev, input logic [7:0] em);
    int n;
    n = 0;
    if (!w) begin
      rd_v.push_back(ev);
      rd_m.push_back(em);
    end
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1) timeout("bus wait");
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask
  task automatic remote(input logic [7:0] b, input logic bad);
    int n;
    n = 0;
    send_byte <= b;
    bad_stop <= bad;
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    @(posedge clk);
    while (busy === 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (n >= 400) timeout("remote wait");
  endtask
  task automatic settle;
    int n;
    n = 0;
    while (tx_q.size() != 0 && n < 600) begin
      @(posedge clk);
      n++;
    end
    if (n >= 600) timeout("transmit wait");
  endtask
  ////////////////////////////////////////////////////////////////
  // monitors take the oldest note when a result shows
  always @(posedge clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      n_tests++;
      if (rd_v.size() == 0) fail("unexpected read");
      else if (((wb_dat_o[7:0] ^ rd_v[0]) & rd_m[0]) !== 8'h00 || wb_dat_o[31:8] !== 24'h0)
        fail("read data");
      if (rd_v.size() != 0) begin
        void'(rd_v.pop_front());
        void'(rd_m.pop_front());
      end
    end
    if (got === 1'b1) begin
      n_tests++;
      if (tx_q.size() == 0 || got_byte !== tx_q[0]) fail("serial byte");
      if (tx_q.size() != 0) void'(tx_q.pop_front());
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    reset = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 12'h000;
    wb_sel_i = 4'h3;
    wb_dat_i = 32'h0;
    send = 1'b0;
    send_byte = 8'h00;
    bad_stop = 1'b0;
    noisy = 1'b0;
    inv = 1'b0;
    seed = 32'h0000_0039; // 57
    err_total = 0;
    n_tests = 0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    bus(1'b0, 12'h918, 32'h0, 8'h00, 8'hFF);
    bus(1'b0, 12'hD1C, 32'h0, 8'h00, 8'hFF);
    bus(1'b0, 12'h91D, 32'h0, 8'h00, 8'hFF);
    bus(1'b0, 12'h010, 32'h0, 8'h00, 8'hFF);
    bus(1'b1, 12'h92C, 32'h1, 8'h00, 8'h00); // 16 clocks a bit
    seed = xs(seed);
    tx_b = seed[7:0];
    rx_b = seed[15:8];
    tx_q.push_back(tx_b);
    // both directions at once; tx byte never reads back
    fork
      remote(rx_b, 1'b0);
      begin
        bus(1'b1, 12'hD1C, {24'h0, tx_b}, 8'h00, 8'h00);
        bus(1'b0, 12'h91C, 32'h0, 8'h00, 8'hFF);
      end
    join
    settle();
    bus(1'b0, 12'hD20, 32'h0, 8'h20, 8'h2F);
    bus(1'b0, 12'h91C, 32'h0, rx_b, 8'hFF);
    bus(1'b0, 12'h920, 32'h0, 8'h00, 8'h2F);
    // inverted frame, then a long inverted idle
    inv <= 1'b1;
    bus(1'b1, 12'h918, 32'h10, 8'h00, 8'h00);
    seed = xs(seed);
    tx_q.push_back(seed[7:0]);
    bus(1'b1, 12'hD1C, seed, 8'h00, 8'h00);
    settle();
    repeat (420) @(posedge clk);
    chk(tx_line, 1'b0, "inverted idle");
    inv <= 1'b0;
    bus(1'b1, 12'h918, 32'h0, 8'h00, 8'h00);
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, 12'h928, {24'h0, cfg_t[k]}, 8'h00, 8'h00);
      noisy <= (k == 3);
      remote(byt_t[k], bad_t[k]);
      if (k == 2) remote(~byt_t[k], 1'b0);
      repeat (4) @(posedge clk);
      chk(irq, 1'b0, "request while disabled");
      bus(1'b1, 12'h918, 32'h1 << bit_t[k], 8'h00, 8'h00);
      chk(irq, 1'b1, "no request when enabled");
      bus(1'b0, 12'h920, 32'h0, 8'h01 << bit_t[k], 8'h01 << bit_t[k]);
      bus(1'b0, 12'h91C, 32'h0, byt_t[k], {8{k >= 2}});
      chk(irq, 1'b0, "request not withdrawn");
      bus(1'b1, 12'h918, 32'h0, 8'h00, 8'h00);
    end
    if (tx_q.size() != 0 || rd_v.size() != 0) fail("results missing");
    report_and_stop();
  end
endmodule
